// file: mcu_io_pkg.sv
package mcu_io_pkg;

    // ---------------------------------------------------------------
    // data memory locations of the port registers
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_L_DATA = 8'hd0;
    localparam logic [7:0] ADDR_L_CFG = 8'hd1;
    localparam logic [7:0] ADDR_L_PIN = 8'hd2;
    localparam logic [7:0] ADDR_G_DATA = 8'hd4;
    localparam logic [7:0] ADDR_G_CFG = 8'hd5;
    localparam logic [7:0] ADDR_G_PIN = 8'hd6;
    localparam logic [7:0] ADDR_I_PIN = 8'hd7;
    localparam logic [7:0] ADDR_C_DATA = 8'hd8;
    localparam logic [7:0] ADDR_C_CFG = 8'hd9;
    localparam logic [7:0] ADDR_C_PIN = 8'hda;
    localparam logic [7:0] ADDR_D_DATA = 8'hdc;

    // ---------------------------------------------------------------
    // reset values and masks
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PORT_D_RST = 8'hff;
    localparam logic [7:0] G_DATA_READ_MASK = 8'h3f;

    // ---------------------------------------------------------------
    // special port bit positions
    // ---------------------------------------------------------------
    localparam int G_HALT_BIT = 7;
    localparam int G_IDLE_BIT = 6;
    localparam int G_DLY_BIT = 7;
    localparam int G_PHASE_BIT = 6;
    localparam int G_IRQ = 0;
    localparam int G_SUPV = 1;
    localparam int G_TMR1_CAP = 2;
    localparam int G_TMR1_IO = 3;
    localparam int G_SO = 4;
    localparam int G_SHIFT_CLK = 5;
    localparam int G_SI = 6;
    localparam int G_OSC_OUT = 7;

    // ---------------------------------------------------------------
    // wake-up port and input-only port bit positions
    // ---------------------------------------------------------------
    localparam int L_USART_CLK = 1;
    localparam int L_TX = 2;
    localparam int L_RX = 3;
    localparam int L_TMR2_A = 4;
    localparam int L_TMR2_B = 5;
    localparam int L_TMR3_A = 6;
    localparam int L_TMR3_B = 7;
    localparam int I_C1N = 1;
    localparam int I_C1P = 2;
    localparam int I_C1O = 3;
    localparam int I_C2N = 4;
    localparam int I_C2P = 5;
    localparam int I_C2O = 6;

endpackage : mcu_io_pkg

// file: pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] pins_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // ---------------------------------------------------------------
    // two-stage synchroniser, first stage read only by the second
    // ---------------------------------------------------------------
    always_comb begin
        s_d.meta = pins;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.sync;

endmodule : pin_sync

// file: pin_mode_decode.sv
module pin_mode_decode #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] cfg,
    input wire logic [WIDTH-1:0] dat,
    input wire logic [WIDTH-1:0] alt_en,
    input wire logic [WIDTH-1:0] alt_val,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_pu
);

    // ---------------------------------------------------------------
    // per-bit setup: hi-z, pull-up input, drive low, drive high
    // ---------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign pin_oe[i] = cfg[i];
        assign pin_out[i] = alt_en[i] ? alt_val[i] : dat[i];
        assign pin_pu[i] = ~cfg[i] & dat[i];
    end

endmodule : pin_mode_decode

// file: mcu_io_port_logic.sv
module mcu_io_port_logic
    import mcu_io_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic [7:0] c_in,
    output logic [7:0] c_out,
    output logic [7:0] c_oe,
    output logic [7:0] c_pu,
    input wire logic [7:0] g_in,
    output logic [7:0] g_out,
    output logic [7:0] g_oe,
    output logic [7:0] g_pu,
    input wire logic [7:0] l_in,
    output logic [7:0] l_out,
    output logic [7:0] l_oe,
    output logic [7:0] l_pu,
    input wire logic [7:0] i_in,
    output logic [7:0] d_out,
    input wire logic xtal_option,
    input wire logic osc_clk,
    input wire logic supervisor_error_n,
    input wire logic idle_exit,
    output logic halt_mode,
    output logic idle_mode,
    output logic restart_delay_enable,
    output logic serial_clock_phase_select,
    input wire logic serial_data_out,
    input wire logic serial_clock_drive,
    input wire logic serial_shift_clock,
    input wire logic timer1_io_out,
    input wire logic timer1_io_drive,
    input wire logic usart_tx_pin,
    input wire logic usart_tx_enable,
    input wire logic [1:0] cmp_enable,
    input wire logic cmp_one_result,
    input wire logic cmp_two_result,
    output logic serial_data_in,
    output logic serial_shift_clock_in,
    output logic timer1_io_pin,
    output logic timer1_capture_pin,
    output logic external_irq_pin,
    output logic [7:0] multi_input_wakeup,
    output logic usart_ext_clock,
    output logic usart_rx_pin,
    output logic timer2_input_a,
    output logic timer2_input_b,
    output logic timer3_input_a,
    output logic timer3_input_b,
    output logic [1:0] cmp_one_inputs,
    output logic [1:0] cmp_two_inputs
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] c_cfg;
        logic [7:0] c_dat;
        logic [7:0] g_cfg;
        logic [7:0] g_dat;
        logic [7:0] l_cfg;
        logic [7:0] l_dat;
        logic [7:0] d_dat;
        logic halt;
        logic idle;
        logic g7_prev;
        logic dly_en;
        logic phase;
        logic [7:0] rdata;
        logic [7:0] c_out;
        logic [7:0] c_oe;
        logic [7:0] c_pu;
        logic [7:0] g_out;
        logic [7:0] g_oe;
        logic [7:0] g_pu;
        logic [7:0] l_out;
        logic [7:0] l_oe;
        logic [7:0] l_pu;
    } state_t;

    localparam state_t STATE_RST = '{d_dat: PORT_D_RST, default: '0};

    state_t s_q;
    state_t s_d;

    logic [7:0] c_sync;
    logic [7:0] g_sync;
    logic [7:0] l_sync;
    logic [7:0] i_sync;
    logic [7:0] c_dout;
    logic [7:0] c_doe;
    logic [7:0] c_dpu;
    logic [7:0] g_dout;
    logic [7:0] g_doe;
    logic [7:0] g_dpu;
    logic [7:0] l_dout;
    logic [7:0] l_doe;
    logic [7:0] l_dpu;
    logic [7:0] g_alt_en;
    logic [7:0] g_alt_val;
    logic [7:0] l_alt_en;
    logic [7:0] l_alt_val;
    logic [7:0] i_read;
    logic halt_wake;
    logic halt_write;
    logic idle_write;

    // ---------------------------------------------------------------
    // pin level synchroniser
    // ---------------------------------------------------------------
    pin_sync #(.WIDTH(32)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .pins({i_in, l_in, g_in, c_in}),
        .pins_sync({i_sync, l_sync, g_sync, c_sync})
    );

    // ---------------------------------------------------------------
    // alternate outputs and pin setup decoding
    // ---------------------------------------------------------------
    always_comb begin
        g_alt_en = '0;
        g_alt_val = '0;
        l_alt_en = '0;
        l_alt_val = '0;
        g_alt_en[G_SO] = 1'b1;
        g_alt_val[G_SO] = serial_data_out;
        g_alt_en[G_SHIFT_CLK] = serial_clock_drive;
        g_alt_val[G_SHIFT_CLK] = serial_shift_clock;
        g_alt_en[G_TMR1_IO] = timer1_io_drive;
        g_alt_val[G_TMR1_IO] = timer1_io_out;
        l_alt_en[L_TX] = usart_tx_enable;
        l_alt_val[L_TX] = usart_tx_pin;
    end

    pin_mode_decode #(.WIDTH(8)) u_dec_c (
        .cfg(s_q.c_cfg),
        .dat(s_q.c_dat),
        .alt_en(8'h00),
        .alt_val(8'h00),
        .pin_out(c_dout),
        .pin_oe(c_doe),
        .pin_pu(c_dpu)
    );

    pin_mode_decode #(.WIDTH(8)) u_dec_g (
        .cfg(s_q.g_cfg),
        .dat(s_q.g_dat),
        .alt_en(g_alt_en),
        .alt_val(g_alt_val),
        .pin_out(g_dout),
        .pin_oe(g_doe),
        .pin_pu(g_dpu)
    );

    pin_mode_decode #(.WIDTH(8)) u_dec_l (
        .cfg(s_q.l_cfg),
        .dat(s_q.l_dat),
        .alt_en(l_alt_en),
        .alt_val(l_alt_val),
        .pin_out(l_dout),
        .pin_oe(l_doe),
        .pin_pu(l_dpu)
    );

    // ---------------------------------------------------------------
    // halt, idle and comparator read-back
    // ---------------------------------------------------------------
    assign halt_wake = ~xtal_option & g_sync[G_OSC_OUT] & ~s_q.g7_prev;
    assign halt_write = cpu_wr && cpu_addr == ADDR_G_DATA && cpu_wdata[G_HALT_BIT];
    assign idle_write = cpu_wr && cpu_addr == ADDR_G_DATA && cpu_wdata[G_IDLE_BIT];

    always_comb begin
        i_read = i_sync;
        if (cmp_enable[0]) begin
            i_read[I_C1O] = cmp_one_result;
        end
        if (cmp_enable[1]) begin
            i_read[I_C2O] = cmp_two_result;
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (cpu_wr) begin
            unique case (cpu_addr)
                ADDR_C_DATA: s_d.c_dat = cpu_wdata;
                ADDR_C_CFG: s_d.c_cfg = cpu_wdata;
                ADDR_G_DATA: s_d.g_dat = cpu_wdata;
                ADDR_G_CFG: s_d.g_cfg = cpu_wdata;
                ADDR_L_DATA: s_d.l_dat = cpu_wdata;
                ADDR_L_CFG: s_d.l_cfg = cpu_wdata;
                ADDR_D_DATA: s_d.d_dat = cpu_wdata;
                default: ;
            endcase
        end
        if (cpu_rd) begin
            unique case (cpu_addr)
                ADDR_C_DATA: s_d.rdata = s_q.c_dat;
                ADDR_C_CFG: s_d.rdata = s_q.c_cfg;
                ADDR_C_PIN: s_d.rdata = c_sync;
                ADDR_G_DATA: s_d.rdata = s_q.g_dat & G_DATA_READ_MASK;
                ADDR_G_CFG: s_d.rdata = s_q.g_cfg;
                ADDR_G_PIN: s_d.rdata = g_sync;
                ADDR_L_DATA: s_d.rdata = s_q.l_dat;
                ADDR_L_CFG: s_d.rdata = s_q.l_cfg;
                ADDR_L_PIN: s_d.rdata = l_sync;
                ADDR_I_PIN: s_d.rdata = i_read;
                ADDR_D_DATA: s_d.rdata = s_q.d_dat;
                default: s_d.rdata = REG_RST;
            endcase
        end
        s_d.g7_prev = g_sync[G_OSC_OUT];
        if (halt_wake) begin
            s_d.halt = 1'b0;
        end
        if (halt_write) begin
            s_d.halt = 1'b1;
        end
        if (idle_exit) begin
            s_d.idle = 1'b0;
        end
        if (idle_write) begin
            s_d.idle = 1'b1;
        end
        s_d.phase = s_q.g_cfg[G_PHASE_BIT];
        s_d.dly_en = s_q.g_cfg[G_DLY_BIT] & ~xtal_option;
        s_d.c_out = c_dout;
        s_d.c_oe = c_doe;
        s_d.c_pu = c_dpu;
        s_d.l_out = l_dout;
        s_d.l_oe = l_doe;
        s_d.l_pu = l_dpu;
        s_d.g_out = g_dout;
        s_d.g_oe = g_doe;
        s_d.g_pu = g_dpu;
        // supervisor error: active low, otherwise released
        s_d.g_out[G_SUPV] = 1'b0;
        s_d.g_oe[G_SUPV] = ~supervisor_error_n;
        s_d.g_pu[G_SUPV] = 1'b0;
        s_d.g_out[G_SI] = 1'b0;
        s_d.g_oe[G_SI] = 1'b0;
        s_d.g_pu[G_SI] = 1'b0;
        s_d.g_out[G_OSC_OUT] = xtal_option & osc_clk;
        s_d.g_oe[G_OSC_OUT] = xtal_option;
        s_d.g_pu[G_OSC_OUT] = 1'b0;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign cpu_rdata = s_q.rdata;
    assign c_out = s_q.c_out;
    assign c_oe = s_q.c_oe;
    assign c_pu = s_q.c_pu;
    assign g_out = s_q.g_out;
    assign g_oe = s_q.g_oe;
    assign g_pu = s_q.g_pu;
    assign l_out = s_q.l_out;
    assign l_oe = s_q.l_oe;
    assign l_pu = s_q.l_pu;
    assign d_out = s_q.d_dat;
    assign halt_mode = s_q.halt;
    assign idle_mode = s_q.idle;
    assign restart_delay_enable = s_q.dly_en;
    assign serial_clock_phase_select = s_q.phase;
    assign serial_data_in = g_sync[G_SI];
    assign serial_shift_clock_in = g_sync[G_SHIFT_CLK];
    assign timer1_io_pin = g_sync[G_TMR1_IO];
    assign timer1_capture_pin = g_sync[G_TMR1_CAP];
    assign external_irq_pin = g_sync[G_IRQ];
    assign multi_input_wakeup = l_sync;
    assign usart_ext_clock = l_sync[L_USART_CLK];
    assign usart_rx_pin = l_sync[L_RX];
    assign timer2_input_a = l_sync[L_TMR2_A];
    assign timer2_input_b = l_sync[L_TMR2_B];
    assign timer3_input_a = l_sync[L_TMR3_A];
    assign timer3_input_b = l_sync[L_TMR3_B];
    assign cmp_one_inputs = {i_sync[I_C1P], i_sync[I_C1N]};
    assign cmp_two_inputs = {i_sync[I_C2P], i_sync[I_C2N]};

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_mode_decode: assert property (1 |=> c_oe == $past(s_q.c_cfg) && c_pu == $past(~s_q.c_cfg & s_q.c_dat))
        else $error("port pin setup does not follow config and data");
    a_port_write: assert property (cpu_wr && cpu_addr == ADDR_D_DATA |=> d_out == $past(cpu_wdata))
        else $error("output port write not applied");
    a_pin_read: assert property (cpu_rd && cpu_addr == ADDR_C_PIN |=> cpu_rdata == $past(c_sync))
        else $error("pin read does not return synchronised levels");
    a_halt_entry: assert property (halt_write |=> halt_mode)
        else $error("halt not entered on write");
    a_idle_entry: assert property (idle_write |=> idle_mode)
        else $error("idle not entered on write");
    a_phase_sel: assert property (cpu_wr && cpu_addr == ADDR_G_CFG |=> ##1
        serial_clock_phase_select == $past(cpu_wdata[G_PHASE_BIT], 2))
        else $error("shift clock phase select not applied");
    a_delay_gate: assert property (1 |-> restart_delay_enable ==
        ($past(s_q.g_cfg[G_DLY_BIT]) && !$past(xtal_option)))
        else $error("restart delay enabled without cause");
    a_data_mask: assert property (cpu_rd && cpu_addr == ADDR_G_DATA |=> cpu_rdata[7:6] == 2'b00)
        else $error("special data bits 6 and 7 read nonzero");
    a_halt_wake: assert property (halt_mode && halt_wake && !halt_write |=> !halt_mode)
        else $error("rising pin 7 did not leave halt");
    a_osc_out: assert property (xtal_option |=> g_oe[G_OSC_OUT] && g_out[G_OSC_OUT] == $past(osc_clk))
        else $error("oscillator clock not driven on pin 7");
    a_supv_pin: assert property (1 |=> g_oe[G_SUPV] == !$past(supervisor_error_n) && !g_out[G_SUPV]
        && !g_oe[G_SI])
        else $error("supervisor or input-only pin misdriven");

endmodule : mcu_io_port_logic

// file: pad_model.sv
module pad_model (
    input wire logic mclk,
    input wire logic [7:0] out,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // pad resolution
    // ---------------------------------------------------------------
    // undriven pads wander so a stale level is never mistaken for a read
    logic [7:0] float_q = 8'h55;

    always @(posedge mclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe[i]) begin
                pad[i] = out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_val[i];
            end else if (pu[i]) begin
                pad[i] = 1'b1;
            end else begin
                pad[i] = float_q[i];
            end
        end
    end
endmodule : pad_model

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcu_io_pkg::*;

    logic mclk, nrst, cpu_wr, cpu_rd, xtal_option, osc_clk, supervisor_error_n, idle_exit;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, i_in, d_out, multi_input_wakeup;
    logic [7:0] c_in, c_out, c_oe, c_pu, g_in, g_out, g_oe, g_pu, l_in, l_out, l_oe, l_pu;
    logic halt_mode, idle_mode, restart_delay_enable, serial_clock_phase_select;
    logic serial_data_out, serial_clock_drive, serial_shift_clock, timer1_io_out, timer1_io_drive;
    logic usart_tx_pin, usart_tx_enable, cmp_one_result, cmp_two_result;
    logic [1:0] cmp_enable, cmp_one_inputs, cmp_two_inputs;
    logic serial_data_in, serial_shift_clock_in, timer1_io_pin, timer1_capture_pin, external_irq_pin;
    logic usart_ext_clock, usart_rx_pin, timer2_input_a, timer2_input_b, timer3_input_a, timer3_input_b;
    logic [7:0] rd_q, exp_d, pc, pl, pg;
    logic [7:0] cf [3];
    logic [7:0] dt [3];
    logic [7:0] ev [3];
    logic [7:0] ee [3];
    int fail_count = 0;
    int checked = 0;
    int seed = 54793;

    mcu_io_port_logic dut (
        .mclk, .nrst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
        .c_in, .c_out, .c_oe, .c_pu, .g_in, .g_out, .g_oe, .g_pu, .l_in, .l_out, .l_oe, .l_pu,
        .i_in, .d_out, .xtal_option, .osc_clk, .supervisor_error_n, .idle_exit, .halt_mode, .idle_mode,
        .restart_delay_enable, .serial_clock_phase_select, .serial_data_out, .serial_clock_drive,
        .serial_shift_clock, .timer1_io_out, .timer1_io_drive, .usart_tx_pin, .usart_tx_enable,
        .cmp_enable, .cmp_one_result, .cmp_two_result, .serial_data_in, .serial_shift_clock_in,
        .timer1_io_pin, .timer1_capture_pin, .external_irq_pin, .multi_input_wakeup, .usart_ext_clock,
        .usart_rx_pin, .timer2_input_a, .timer2_input_b, .timer3_input_a, .timer3_input_b,
        .cmp_one_inputs, .cmp_two_inputs
    );
    pad_model pm_c (.mclk, .out(c_out), .oe(c_oe), .pu(c_pu), .ext_val(ev[0]), .ext_en(ee[0]), .pad(c_in));
    pad_model pm_l (.mclk, .out(l_out), .oe(l_oe), .pu(l_pu), .ext_val(ev[1]), .ext_en(ee[1]), .pad(l_in));
    pad_model pm_g (.mclk, .out(g_out), .oe(g_oe), .pu(g_pu), .ext_val(ev[2]), .ext_en(ee[2]), .pad(g_in));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge mclk);
        cpu_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge mclk);
        cpu_rd = 1'b0;
        @(negedge mclk);
        rd_q = cpu_rdata;
    endtask : rd

    task automatic print_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    function automatic logic [7:0] pad_exp(input logic [7:0] drv, input logic [7:0] val, input logic [7:0] ext);
        return (drv & val) | (~drv & ext);
    endfunction : pad_exp

    function automatic logic [7:0] g_val(input logic [7:0] d);
        return {d[7:6], serial_clock_drive ? serial_shift_clock : d[5], serial_data_out,
                timer1_io_drive ? timer1_io_out : d[3], d[2:0]};
    endfunction : g_val

    function automatic logic [7:0] l_val(input logic [7:0] d);
        return {d[7:3], usart_tx_enable ? usart_tx_pin : d[2], d[1:0]};
    endfunction : l_val

    initial begin
        #2000000;
        fail_count++;
        print_verdict();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        static logic [7:0] ra [7] = '{ADDR_C_DATA, ADDR_C_CFG, ADDR_L_DATA, ADDR_L_CFG, ADDR_G_DATA, ADDR_G_CFG, 8'h10};
        nrst = 1'b0;
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata, i_in, xtal_option, osc_clk, idle_exit} = '0;
        supervisor_error_n = 1'b1;
        {serial_data_out, serial_clock_drive, serial_shift_clock, timer1_io_out, timer1_io_drive} = '0;
        {usart_tx_pin, usart_tx_enable, cmp_enable, cmp_one_result, cmp_two_result} = '0;
        for (int k = 0; k < 3; k++) begin
            ev[k] = 8'h00;
            ee[k] = 8'h00;
        end
        repeat (3) @(negedge mclk);
        chk("d_out_rst", d_out, PORT_D_RST);
        chk("oe_rst", c_oe | g_oe | l_oe, 8'h00);
        nrst = 1'b1;
        wr(8'h10, 8'hff);
        foreach (ra[k]) begin
            rd(ra[k]);
            chk("reg_rst", rd_q, REG_RST);
        end
        for (int n = 0; n < 24; n++) begin
            for (int k = 0; k < 3; k++) begin
                cf[k] = 8'($random(seed));
                dt[k] = 8'($random(seed));
                ev[k] = 8'($random(seed));
                ee[k] = ~cf[k];
            end
            dt[2] = dt[2] & 8'h3f;
            ee[2] = ~(cf[2] & 8'h3d);
            {serial_data_out, serial_clock_drive, serial_shift_clock, timer1_io_out, timer1_io_drive,
             usart_tx_pin, usart_tx_enable, cmp_one_result} = 8'($random(seed));
            {cmp_two_result, cmp_enable} = 3'($random(seed));
            i_in = 8'($random(seed));
            exp_d = 8'($random(seed));
            wr(ADDR_C_CFG, cf[0]);
            wr(ADDR_C_DATA, dt[0]);
            wr(ADDR_L_CFG, cf[1]);
            wr(ADDR_L_DATA, dt[1]);
            wr(ADDR_G_CFG, cf[2]);
            wr(ADDR_G_DATA, dt[2]);
            wr(ADDR_D_DATA, exp_d);
            repeat (3) @(negedge mclk);
            pc = pad_exp(cf[0], dt[0], ev[0]);
            pl = pad_exp(cf[1], l_val(dt[1]), ev[1]);
            pg = pad_exp(cf[2] & 8'h3d, g_val(dt[2]), ev[2]);
            chk("c_oe", c_oe, cf[0]);
            chk("c_out", c_out & cf[0], dt[0] & cf[0]);
            chk("c_pu", c_pu, ~cf[0] & dt[0]);
            chk("l_oe", l_oe, cf[1]);
            chk("l_out", l_out & cf[1], l_val(dt[1]) & cf[1]);
            chk("l_pu", l_pu, ~cf[1] & dt[1]);
            chk("g_oe", g_oe, cf[2] & 8'h3d);
            chk("g_out", g_out & cf[2] & 8'h3d, g_val(dt[2]) & cf[2] & 8'h3d);
            chk("g_pu", g_pu, ~cf[2] & dt[2] & 8'h3d);
            chk("phase", {7'h00, serial_clock_phase_select}, {7'h00, cf[2][6]});
            chk("delay", {7'h00, restart_delay_enable}, {7'h00, cf[2][7]});
            chk("d_out", d_out, exp_d);
            chk("l_wake", multi_input_wakeup, pl);
            chk("l_alt", {2'b00, usart_ext_clock, usart_rx_pin, timer2_input_a, timer2_input_b, timer3_input_a,
                timer3_input_b}, {2'b00, pl[1], pl[3], pl[4], pl[5], pl[6], pl[7]});
            chk("g_alt", {3'b000, serial_data_in, serial_shift_clock_in, timer1_io_pin, timer1_capture_pin,
                external_irq_pin}, {3'b000, pg[6], pg[5], pg[3], pg[2], pg[0]});
            chk("cmp_in", {4'h0, cmp_two_inputs, cmp_one_inputs}, {4'h0, i_in[5:4], i_in[2:1]});
            rd(ADDR_C_PIN);
            chk("c_pin", rd_q, pc);
            rd(ADDR_L_PIN);
            chk("l_pin", rd_q, pl);
            rd(ADDR_G_PIN);
            chk("g_pin", rd_q, pg);
            rd(ADDR_I_PIN);
            chk("i_pin", rd_q, {i_in[7], cmp_enable[1] ? cmp_two_result : i_in[6], i_in[5:4],
                cmp_enable[0] ? cmp_one_result : i_in[3], i_in[2:0]});
            rd(ADDR_C_DATA);
            chk("c_data", rd_q, dt[0]);
            rd(ADDR_L_CFG);
            chk("l_cfg", rd_q, cf[1]);
            rd(ADDR_G_CFG);
            chk("g_cfg", rd_q, cf[2]);
        end
        ev[2] = 8'h00;
        ee[2] = 8'hff;
        wr(ADDR_G_CFG, 8'h80);
        wr(ADDR_G_DATA, 8'hc5);
        @(negedge mclk);
        chk("modes", {6'h00, halt_mode, idle_mode}, 8'h03);
        chk("delay_on", {7'h00, restart_delay_enable}, 8'h01);
        rd(ADDR_G_DATA);
        chk("g_data", rd_q, 8'h05);
        idle_exit = 1'b1;
        @(negedge mclk);
        idle_exit = 1'b0;
        @(negedge mclk);
        chk("idle_exit", {6'h00, halt_mode, idle_mode}, 8'h02);
        ev[2] = 8'h80;
        @(negedge mclk);
        chk("halt_hold", {g_oe[7], halt_mode}, 2'b01);
        repeat (3) @(negedge mclk);
        chk("halt_wake", {7'h00, halt_mode}, 8'h00);
        xtal_option = 1'b1;
        osc_clk = 1'b1;
        repeat (3) @(negedge mclk);
        chk("xtal_hi", {g_oe[7], g_out[7], restart_delay_enable}, 3'b110);
        osc_clk = 1'b0;
        repeat (3) @(negedge mclk);
        chk("xtal_lo", {g_oe[7], g_out[7]}, 2'b10);
        xtal_option = 1'b0;
        supervisor_error_n = 1'b0;
        repeat (2) @(negedge mclk);
        chk("supv", {g_oe[1], g_out[1]}, 2'b10);
        supervisor_error_n = 1'b1;
        wr(ADDR_C_CFG, 8'hff);
        wr(ADDR_D_DATA, 8'h5a);
        repeat (3) @(negedge mclk);
        chk("d_out", d_out, 8'h5a);
        nrst = 1'b0;
        #5;
        chk("d_out_rst2", d_out, PORT_D_RST);
        chk("c_oe_rst2", c_oe, 8'h00);
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        rd(ADDR_C_CFG);
        chk("c_cfg_rst2", rd_q, REG_RST);
        print_verdict();
    end
endmodule : tb
